//--- asrc_host.sv
// host controller that drives a 256K x 4 asynchronous static memory through its pins
`timescale 1ns/1ps
// Operation
// - write spans last fall to first rise
// - address valid before write end
// - select low before write end
// - wait recovery time after retention
// - address valid by select fall
module asrc_host (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // user request
  input  wire asrc_pkg::asrc_req_t           req,
  output logic                               req_ready,
  output logic [asrc_pkg::DATA_W-1:0]        rdata,
  output logic                               rdata_valid,
  // retention control
  input  wire logic                          retain_req,
  output logic                               retaining,
  // memory pins
  output asrc_pkg::asrc_pins_t               pins,
  input  wire logic [asrc_pkg::DATA_W-1:0]   dq_in
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    asrc_pkg::asrc_state_t         st;
    logic [asrc_pkg::CNT_W-1:0]    cnt;
    asrc_pkg::asrc_pins_t          pins;
    logic                          ready;
    logic [asrc_pkg::DATA_W-1:0]   rdata;
    logic                          rvalid;
    logic                          retaining;
  } asrc_ctl_t;

  asrc_ctl_t s_q;
  asrc_ctl_t s_d;

  localparam asrc_pkg::asrc_pins_t PINS_IDLE = '{
    addr: '0, sel_n: 1'b1, outen_n: 1'b1, wstrobe_n: 1'b1, dq_out: '0, dq_oe: 1'b0};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    if (s_q.cnt != asrc_pkg::CNT_ZERO) begin
      s_d.cnt = s_q.cnt - asrc_pkg::CNT_ONE;
    end
    case (s_q.st)
      asrc_pkg::ST_IDLE: begin
        // bus stays released: select and strobes high, no drive
        s_d.pins  = PINS_IDLE;
        s_d.ready = 1'b1;
        if (retain_req) begin
          // retention entry may follow deselect at once
          s_d.st        = asrc_pkg::ST_RETAIN;
          s_d.ready     = 1'b0;
          s_d.retaining = 1'b1;
        end else if (req.valid && s_q.ready) begin
          s_d.ready      = 1'b0;
          // address goes out with select so it is valid by the select fall
          s_d.pins.addr  = req.addr;
          s_d.pins.sel_n = 1'b0;
          if (req.write) begin
            // write data and strobe go low with select; outen stays high
            s_d.pins.wstrobe_n = 1'b0;
            s_d.pins.dq_out    = req.wdata;
            s_d.pins.dq_oe     = 1'b1;
            s_d.st             = asrc_pkg::ST_WRITE;
            s_d.cnt            = asrc_pkg::STROBE_CYC;
          end else begin
            s_d.pins.outen_n = 1'b0;
            s_d.st           = asrc_pkg::ST_READ;
            s_d.cnt          = asrc_pkg::READ_WAIT_CYC;
          end
        end
      end
      asrc_pkg::ST_READ: begin
        if (s_q.cnt == asrc_pkg::CNT_ZERO) begin
          // sample after the full access time, then deselect
          s_d.rdata  = dq_in;
          s_d.rvalid = 1'b1;
          s_d.pins   = PINS_IDLE;
          // wait for the device float before the next cycle may drive
          s_d.cnt    = asrc_pkg::FLOAT_CYC;
          s_d.st     = asrc_pkg::ST_WHOLD;
        end
      end
      asrc_pkg::ST_WRITE: begin
        if (s_q.cnt == asrc_pkg::CNT_ZERO) begin
          // strobe and select rise together; data held this edge and one more cycle until ST_WHOLD drops dq_oe
          s_d.pins.wstrobe_n = 1'b1;
          s_d.pins.sel_n     = 1'b1;
          s_d.st             = asrc_pkg::ST_WHOLD;
          s_d.cnt            = asrc_pkg::CNT_ONE;
        end
      end
      asrc_pkg::ST_WHOLD: begin
        s_d.pins.dq_oe = 1'b0;
        if (s_q.cnt == asrc_pkg::CNT_ZERO) begin
          s_d.st = asrc_pkg::ST_IDLE;
        end
      end
      asrc_pkg::ST_RETAIN: begin
        s_d.pins = PINS_IDLE;
        if (!retain_req) begin
          s_d.st  = asrc_pkg::ST_RECOVER;
          s_d.cnt = asrc_pkg::RECOVER_CYC;
        end
      end
      asrc_pkg::ST_RECOVER: begin
        if (s_q.cnt == asrc_pkg::CNT_ZERO) begin
          s_d.retaining = 1'b0;
          s_d.st        = asrc_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st   = asrc_pkg::ST_IDLE;
        s_d.pins = PINS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q.st        <= asrc_pkg::ST_IDLE;
      s_q.cnt       <= '0;
      s_q.pins      <= PINS_IDLE;
      s_q.ready     <= 1'b0;
      s_q.rdata     <= '0;
      s_q.rvalid    <= 1'b0;
      s_q.retaining <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins        = s_q.pins;
  assign req_ready   = s_q.ready;
  assign rdata       = s_q.rdata;
  assign rdata_valid = s_q.rvalid;
  assign retaining   = s_q.retaining;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_never_drive_in_read;
    @(posedge core_clk) disable iff (rst) !(pins.dq_oe && !pins.outen_n);
  endproperty
  a_never_drive_in_read: assert property (p_never_drive_in_read)
    else $error("host drives bus while memory outputs enabled");

  property p_strobe_len;
    @(posedge core_clk) disable iff (rst)
      $fell(pins.wstrobe_n) |-> !pins.wstrobe_n [*2] ##1 pins.wstrobe_n;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("write strobe width wrong");

  property p_write_data_stable;
    @(posedge core_clk) disable iff (rst)
      !pins.wstrobe_n && !$fell(pins.wstrobe_n) |-> $stable(pins.dq_out) && pins.dq_oe;
  endproperty
  a_write_data_stable: assert property (p_write_data_stable)
    else $error("write data moved during strobe");

  property p_addr_stable_write;
    @(posedge core_clk) disable iff (rst)
      !pins.wstrobe_n && !$fell(pins.wstrobe_n) |-> $stable(pins.addr);
  endproperty
  a_addr_stable_write: assert property (p_addr_stable_write)
    else $error("address moved during write");

  property p_sel_with_strobe;
    @(posedge core_clk) disable iff (rst) !pins.wstrobe_n |-> !pins.sel_n;
  endproperty
  a_sel_with_strobe: assert property (p_sel_with_strobe)
    else $error("strobe low without select");

  property p_read_len;
    @(posedge core_clk) disable iff (rst)
      $fell(pins.outen_n) |-> !pins.outen_n ##1 (!pins.outen_n && $stable(pins.addr))
        ##1 rdata_valid;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read cycle length wrong");

  property p_addr_with_sel;
    @(posedge core_clk) disable iff (rst)
      !pins.sel_n && !$fell(pins.sel_n) |-> $stable(pins.addr);
  endproperty
  a_addr_with_sel: assert property (p_addr_with_sel)
    else $error("address changed while selected");

  property p_recover;
    @(posedge core_clk) disable iff (rst)
      $fell(retaining) |-> $past(retain_req, 3) == 1'b0 && pins.sel_n;
  endproperty
  a_recover: assert property (p_recover)
    else $error("retention recovery too short");

  c_read:   cover property (@(posedge core_clk) disable iff (rst) rdata_valid);
  c_write:  cover property (@(posedge core_clk) disable iff (rst) $rose(pins.wstrobe_n));
  c_retain: cover property (@(posedge core_clk) disable iff (rst) $fell(retaining));

endmodule : asrc_host

//--- asrc_pkg.sv
// package: pin timing, state encoding and port structs for the static memory host controller
package asrc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 4;

  // ----------------------------------------------------------------
  // timing (fastest grade, ns) and cycle counts at core_clk
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS           = 20;
  localparam int unsigned READ_PERIOD_MIN_NS      = 20;
  localparam int unsigned WRITE_PERIOD_MIN_NS     = 20;
  localparam int unsigned ADDR_TO_DATA_TIME_NS    = 20;
  localparam int unsigned STROBE_LOW_MIN_NS       = 15;
  localparam int unsigned WDATA_SETUP_MIN_NS      = 8;
  localparam int unsigned ADDR_BEFORE_WRITE_END_NS = 12;
  localparam int unsigned RETENTION_RECOVERY_NS   = 20;
  localparam int unsigned DESELECT_FLOAT_TIME_NS  = 8;

  localparam int unsigned CNT_W = 4;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam logic [CNT_W-1:0] READ_WAIT_CYC =
    CNT_W'(ns_to_cyc(ADDR_TO_DATA_TIME_NS));
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'(ns_to_cyc(STROBE_LOW_MIN_NS));
  localparam logic [CNT_W-1:0] RECOVER_CYC =
    CNT_W'(ns_to_cyc(RETENTION_RECOVERY_NS));
  localparam logic [CNT_W-1:0] FLOAT_CYC =
    CNT_W'(ns_to_cyc(DESELECT_FLOAT_TIME_NS));
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_READ    = 6'h02,
    ST_WRITE   = 6'h04,
    ST_WHOLD   = 6'h08,
    ST_RETAIN  = 6'h10,
    ST_RECOVER = 6'h20
  } asrc_state_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              sel_n;
    logic              outen_n;
    logic              wstrobe_n;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } asrc_pins_t;

endpackage : asrc_pkg

//--- asrc_mem_model.sv
// behavioural model of the 256K x 4 static memory facing the host controller
`timescale 1ns/1ps
module asrc_mem_model (
  // pins from the host
  input  wire logic [17:0] addr,
  input  wire logic        sel_n,
  input  wire logic        outen_n,
  input  wire logic        wstrobe_n,
  input  wire logic [3:0]  host_dq,
  input  wire logic        host_oe,
  // resolved data bus
  output logic [3:0]       dq_level
);
  logic [3:0]  mem [0:262143];
  logic [3:0]  last_v;
  logic [17:0] row;
  logic        dev_oe;
  logic        wr_act;
  // any bijective decode keeps the words apart
  assign row    = {addr[17:4], addr[3] ^ addr[11], addr[2:0]};
  // zero-delay drive and float sit inside every access, hold and float bound
  assign dev_oe = !sel_n && !outen_n && wstrobe_n;
  assign wr_act = !sel_n && !wstrobe_n;
  initial last_v = 4'h0;
  // a released bus shows the inverse of its last value so stale data never passes
  always_comb begin
    if (host_oe) dq_level = host_dq;
    else if (dev_oe) dq_level = mem[row];
    else dq_level = ~last_v;
  end
  always @(dq_level or host_oe or dev_oe) begin
    if (host_oe || dev_oe) last_v = dq_level;
  end
  always @(negedge wr_act) begin
    mem[row] = dq_level;  // first rise of either strobe ends the write
  end
endmodule : asrc_mem_model

//--- asrc_host_tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
module asrc_host_tb;
  logic                 core_clk;
  logic                 rst;
  asrc_pkg::asrc_req_t  req;
  logic                 req_ready;
  logic [3:0]           rdata;
  logic                 rdata_valid;
  logic                 retain_req;
  logic                 retaining;
  asrc_pkg::asrc_pins_t pins;
  logic [3:0]           dq_in;
  int                   n_fail;
  int                   n_tests;
  int                   cyc;
  logic [17:0]          addr_tab [5] = '{18'h00000, 18'h3ffff, 18'h00808, 18'h00800, 18'h00008};

  asrc_host uut (.core_clk(core_clk), .rst(rst), .req(req), .req_ready(req_ready),
    .rdata(rdata), .rdata_valid(rdata_valid), .retain_req(retain_req),
    .retaining(retaining), .pins(pins), .dq_in(dq_in));
  asrc_mem_model mem_dev (.addr(pins.addr), .sel_n(pins.sel_n), .outen_n(pins.outen_n),
    .wstrobe_n(pins.wstrobe_n), .host_dq(pins.dq_out), .host_oe(pins.dq_oe), .dq_level(dq_in));

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // called at a rising edge; returns just after the taking edge
  task automatic issue(input logic wr, input logic [17:0] a, input logic [3:0] d);
    int k;
    k = 0;
    req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge core_clk);
    while (req_ready !== 1'b1 && k < 20) begin
      k++;
      @(posedge core_clk);
    end
    req.valid <= 1'b0;
    check(req_ready, 1'b1);
  endtask : issue

  task automatic do_write(input logic [17:0] a, input logic [3:0] d);
    issue(1'b1, a, d);
    #1;
    check({pins.sel_n, pins.wstrobe_n, pins.outen_n, pins.dq_oe}, 4'h3);
    check({pins.addr, pins.dq_out}, {a, d});
    @(posedge core_clk);
    #1;
    check({pins.sel_n, pins.wstrobe_n}, 2'h0);
    @(posedge core_clk);
    #1;
    check({pins.sel_n, pins.wstrobe_n, pins.dq_oe, pins.dq_out}, {3'h7, d});
    @(posedge core_clk);
    #1;
    check(pins.dq_oe, 1'b0);
    repeat (2) @(posedge core_clk);
  endtask : do_write

  task automatic do_read(input logic [17:0] a, input logic [3:0] exp);
    issue(1'b0, a, 4'h0);
    #1;
    check({pins.sel_n, pins.outen_n, pins.wstrobe_n, pins.dq_oe}, 4'h2);
    check(pins.addr, a);
    repeat (2) @(posedge core_clk);
    #1;
    check({rdata_valid, rdata}, {1'b1, exp});
    check({pins.sel_n, pins.outen_n}, 2'h3);
    @(posedge core_clk);
    #1;
    check(rdata_valid, 1'b0);
    @(posedge core_clk);
  endtask : do_read

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // a write held pending through retention must wait for recovery
  task automatic do_retain();
    int k;
    k = 0;
    retain_req <= 1'b1;
    req <= '{valid: 1'b1, write: 1'b1, addr: 18'h00808, wdata: 4'h9};
    repeat (4) @(posedge core_clk);
    #1;
    check({retaining, pins.sel_n, pins.wstrobe_n}, 3'h7);
    @(posedge core_clk);
    retain_req <= 1'b0;
    do begin
      @(posedge core_clk);
      #1;
      if (retaining === 1'b1) check(pins.sel_n, 1'b1);
      k++;
    end while (pins.sel_n !== 1'b0 && k < 12);
    check(k > 1 && k < 12, 1'b1);
    @(posedge core_clk);
    req.valid <= 1'b0;
    repeat (4) @(posedge core_clk);
    do_read(18'h00808, 4'h9);
  endtask : do_retain

  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    req = '0;
    retain_req = 1'b0;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    check({pins.sel_n, pins.outen_n, pins.wstrobe_n, pins.dq_oe, req_ready, retaining},
          6'h38);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    foreach (addr_tab[i]) do_write(addr_tab[i], 4'(i + 3));
    foreach (addr_tab[i]) do_read(addr_tab[i], 4'(i + 3));
    do_write(18'h3ffff, 4'hc);
    do_read(18'h3ffff, 4'hc);
    do_retain();
    results();
  end
endmodule : asrc_host_tb
